// [hw/dbsp_port.sv]
// Function
// - Load low, read high at rise: read
// - Read address captured on command edge
// - Each read returns four full-width words
// - First word on output fall after input fall
// - Following words alternate output rise and fall
// - Back-to-back reads pipeline without gaps
// - Both output clocks high: use input clocks
// - Deselect after load high, burst still completes
// - Data lines released after finished burst
// - Load low, read low at rise: write
// - Write address registered on command rise
// - Each write stores four full-width words
// - First write word taken next main rise
// - Second write word taken inverted rise
// - Continuous writes register every clock edge
// - Deselect outside a burst ignores data driven that cycle
// - Narrow variant: lanes zero and one
// - Wide variant: lanes zero to three
// - Lane written only with strobe low
// - New cycle only when load sampled low
// - DLL held off while disable pin low
// - Pending operations complete before clock stop
// - Burst order linear, wraps modulo four
`include "dbsp_defines.svh"

// Read word buffer between array fetch and pin drive
module dbsp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import dbsp_pkg::*;
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} dbsp_fifo_s;
	dbsp_fifo_s st;
	dbsp_fifo_s n;
	logic push;
	logic pop;

	// Pointers wrap naturally, so DEPTH must be a power of two
	assign in_ready = st.cnt != (PW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = st.mem[st.rp];

	// Next state
	always_comb begin
		n = st;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			n.mem[st.wp] = in_data;
			n.wp = st.wp + 1'b1;
		end
		if (pop) begin
			n.rp = st.rp + 1'b1;
		end
		n.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end
endmodule

// Memory-side port of the burst-of-four static memory
module dbsp_port #(
	parameter int LANES = `DBSP_LANES,
	parameter int DEPTH = `DBSP_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input dbsp_pkg::dbsp_pins_s pins,
	output dbsp_pkg::dbsp_dq_s dq,
	output logic dll_enabled,
	output logic dll_locked,
	output logic busy
);
	import dbsp_pkg::*;
	localparam int AW = `DBSP_AW;
	localparam int MW = 2 ** (AW + 2);
	localparam int LW = `DBSP_LANE_W;

	typedef struct packed {
		dbsp_pins_s s1;
		dbsp_pins_s s2;
		logic [3:0] clk_d;
		logic single;
		logic pend_rd;
		dbsp_addr_t rd_addr;
		logic freq;
		logic fetch;
		dbsp_addr_t f_addr;
		logic [1:0] f_idx;
		logic [`DBSP_ARM_W-1:0] arm_cnt;
		logic out_act;
		logic [1:0] out_idx;
		logic hold;
		dbsp_addr_t hold_addr;
		logic wr_act;
		dbsp_addr_t wr_addr;
		logic [1:0] wr_idx;
		logic [`DBSP_LOCK_W-1:0] lock_cnt;
		logic [MW-1:0][`DBSP_DW-1:0] mem;
		dbsp_dq_s dq;
		logic dll_en;
		logic locked;
		logic busy;
	} dbsp_st_s;

	dbsp_st_s st;
	dbsp_st_s n;
	logic k_rise;
	logic kn_rise;
	logic out_rise;
	logic out_fall;
	logic c_fall;
	logic rd_cmd;
	logic wr_cmd;
	dbsp_addr_t cmd_addr;
	logic [`DBSP_ARM_W-1:0] arm;
	logic wr_en;
	dbsp_addr_t wa;
	logic pop;
	logic fifo_ir;
	logic fifo_ov;
	logic [`DBSP_DW-1:0] fifo_od;

	// Linear burst order inside the aligned group of four
	function automatic dbsp_addr_t bidx(dbsp_addr_t a, logic [1:0] i);
		return {a[AW+1:2], 2'(a[1:0] + i)};
	endfunction

	// Edges of the synchronised clocks; clk_d holds k, k_n, c, c_n
	assign k_rise = st.s2.main_clk && !st.clk_d[3];
	assign kn_rise = st.s2.main_clk_n && !st.clk_d[2];
	assign c_fall = (st.clk_d[1] && !st.s2.out_clk) || (st.clk_d[0] && !st.s2.out_clk_n);
	assign out_rise = st.single ? k_rise : (st.s2.out_clk && !st.clk_d[1]);
	assign out_fall = st.single ? kn_rise : (st.s2.out_clk_n && !st.clk_d[0]);

	// Commands exist only where load is sampled low on a main rise
	assign rd_cmd = k_rise && !st.s2.load_n && st.s2.read_not_write;
	assign wr_cmd = k_rise && !st.s2.load_n && !st.s2.read_not_write;
	assign cmd_addr = {st.s2.addr_in, st.s2.burst_low_addr_bit1, st.s2.burst_low_addr_bit0};

	// Fetched read words wait here until the output clocks take them
	dbsp_fifo #(
		.W(`DBSP_DW),
		.DEPTH(DEPTH)
	) u_rbuf (
		.clk(mclk),
		.rst_n(rst_n),
		.in_valid(st.fetch),
		.in_ready(fifo_ir),
		.in_data(st.mem[bidx(st.f_addr, st.f_idx)]),
		.out_valid(fifo_ov),
		.out_ready(pop),
		.out_data(fifo_od)
	);

	// Next state of the whole port
	always_comb begin
		n = st;
		wr_en = 1'h0;
		wa = '0;
		pop = 1'h0;
		n.s1 = pins;
		n.s2 = st.s1;
		n.clk_d = {st.s2.main_clk, st.s2.main_clk_n, st.s2.out_clk, st.s2.out_clk_n};
		// A fall on either output clock means the dual clock mode is in use
		if (c_fall) begin
			n.single = 1'h0;
		end
		if (kn_rise) begin
			n.pend_rd = 1'h0;
		end
		if (rd_cmd) begin
			n.pend_rd = 1'h1;
			n.rd_addr = cmd_addr;
			n.freq = 1'h1;
		end
		// Fetch four words; a full buffer stalls the fetch
		if (!st.fetch && st.freq) begin
			n.fetch = 1'h1;
			n.f_addr = st.rd_addr;
			n.f_idx = `DBSP_W0;
			n.freq = rd_cmd;
		end else if (st.fetch && fifo_ir) begin
			n.f_idx = st.f_idx + 1'b1;
			if (st.f_idx == `DBSP_WLAST) begin
				n.fetch = 1'h0;
			end
		end
		// A read becomes due at the inverted rise after its command
		arm = st.arm_cnt + `DBSP_ARM_W'(kn_rise && st.pend_rd);
		// Output engine: one word per output edge, chained bursts
		if (out_rise || out_fall) begin
			if (st.out_act && st.out_idx != `DBSP_WLAST) begin
				if (fifo_ov) begin
					pop = 1'h1;
					n.dq.data_lines = fifo_od;
					n.out_idx = st.out_idx + 1'b1;
				end
			end else if (out_fall && arm != '0 && fifo_ov) begin
				pop = 1'h1;
				n.dq.data_lines = fifo_od;
				n.dq.data_oe = 1'h1;
				n.out_idx = `DBSP_W0;
				n.out_act = 1'h1;
				arm = arm - 1'b1;
			end else if (st.out_act) begin
				n.out_act = 1'h0;
				n.dq.data_oe = 1'h0;
			end
		end
		n.arm_cnt = arm;
		// Write words: K rise takes words 0 and 2, K_n rise 1 and 3
		if (k_rise) begin
			if (st.wr_act && st.wr_idx == `DBSP_W2) begin
				wr_en = 1'h1;
				wa = bidx(st.wr_addr, `DBSP_W2);
				n.wr_idx = `DBSP_WLAST;
			end else if (st.hold) begin
				wr_en = 1'h1;
				wa = bidx(st.hold_addr, `DBSP_W0);
				n.wr_act = 1'h1;
				n.wr_addr = st.hold_addr;
				n.wr_idx = `DBSP_W1;
				n.hold = 1'h0;
			end
			// Data on a deselect edge outside a burst is never taken
			if (wr_cmd) begin
				n.hold = 1'h1;
				n.hold_addr = cmd_addr;
			end
		end
		if (kn_rise && st.wr_act) begin
			wr_en = 1'h1;
			wa = bidx(st.wr_addr, st.wr_idx);
			n.wr_idx = st.wr_idx + 1'b1;
			if (st.wr_idx == `DBSP_WLAST) begin
				n.wr_act = 1'h0;
			end
		end
		// Lane gating; lanes beyond LANES never write
		if (wr_en) begin
			for (int l = 0; l < LANES; l++) begin
				if (!st.s2.lane_write_n[l]) begin
					n.mem[wa][l*LW +: LW] = st.s2.data_lines[l*LW +: LW];
				end
			end
		end
		// DLL enable and lock wait, counted in main clock periods
		n.dll_en = st.s2.dll_disable_n;
		if (!st.dll_en) begin
			n.lock_cnt = '0;
			n.locked = 1'h0;
		end else if (k_rise && !st.locked) begin
			n.lock_cnt = st.lock_cnt + 1'b1;
			if (st.lock_cnt == `DBSP_LOCK_LAST) begin
				n.locked = 1'h1;
			end
		end
		// Clocks must keep running until this drops
		n.busy = st.pend_rd || st.freq || st.fetch || arm != '0
			|| st.out_act || st.hold || st.wr_act;
	end

	// State register; power-up assumes single clock mode until C or C_n falls
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
			st.single <= 1'h1;
		end else begin
			st <= n;
		end
	end

	assign dq = st.dq;
	assign dll_enabled = st.dll_en;
	assign dll_locked = st.locked;
	assign busy = st.busy;

	// Helper: a burst may only start when one is due
	logic arm_prev_ok;
	assign arm_prev_ok = st.arm_cnt != '0 || (kn_rise && st.pend_rd);

	default clocking cb_m @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_rd_cmd;
		k_rise && !st.s2.load_n && st.s2.read_not_write;
	endsequence
	sequence s_wr_cmd;
		k_rise && !st.s2.load_n && !st.s2.read_not_write;
	endsequence
	sequence s_start;
		pop && (!st.out_act || st.out_idx == `DBSP_WLAST);
	endsequence

	AST_RD_ACCEPT: assert property (s_rd_cmd |=> st.pend_rd && st.freq)
		else $error("read command not accepted");
	AST_RD_ADDR: assert property (s_rd_cmd |=> st.rd_addr == $past(cmd_addr))
		else $error("read address not captured");
	AST_BURST4: assert property ($fell(st.out_act) |-> $past(st.out_idx) == `DBSP_WLAST)
		else $error("read burst ended early");
	AST_FIRST_FALL: assert property (s_start |-> out_fall && (arm_prev_ok))
		else $error("first read word not on falling output edge");
	AST_ALT: assert property (pop && st.out_act && st.out_idx != `DBSP_WLAST
		|-> (st.out_idx[0] ? out_fall : out_rise))
		else $error("burst words not on alternating edges");
	AST_RELEASE: assert property ($fell(st.dq.data_oe)
		|-> $past(st.out_idx) == `DBSP_WLAST && $past(out_fall))
		else $error("data lines released at wrong time");
	AST_WR_CMD: assert property (s_wr_cmd
		|=> st.hold && st.hold_addr == $past(cmd_addr))
		else $error("write command not held");
	AST_DESEL: assert property (k_rise && st.s2.load_n && !st.hold
		|=> !st.hold && !$rose(st.pend_rd))
		else $error("cycle started with load high");
	AST_NOLANE: assert property (wr_en && (&st.s2.lane_write_n) |=> $stable(st.mem))
		else $error("memory written with all strobes high");
	AST_DLL: assert property (!st.s2.dll_disable_n |=> !dll_enabled ##1 !dll_locked)
		else $error("DLL not held off");
endmodule

// [hw/dbsp_defines.svh]
`ifndef DBSP_DEFINES_SVH
`define DBSP_DEFINES_SVH
// Data width of the wide variant and lane layout
`define DBSP_DW 36
`define DBSP_LANE_W 9
`define DBSP_LANES 4
// Word address width above the two burst bits
`define DBSP_AW 4
// Burst word indexes
`define DBSP_W0 2'h0
`define DBSP_W1 2'h1
`define DBSP_W2 2'h2
`define DBSP_WLAST 2'h3
// Read word buffer depth
`define DBSP_FIFO_DEPTH 32
// Queued burst counter width
`define DBSP_ARM_W 4
// DLL lock wait: 1024 input clock cycles
`define DBSP_LOCK_W 11
`define DBSP_LOCK_LAST 11'h3FF
`endif

// [hw/dbsp_pkg.sv]
`include "dbsp_defines.svh"
package dbsp_pkg;
	// Pins from the memory controller, as seen at the balls
	typedef struct packed {
		logic main_clk;
		logic main_clk_n;
		logic out_clk;
		logic out_clk_n;
		logic load_n;
		logic read_not_write;
		logic [`DBSP_AW-1:0] addr_in;
		logic burst_low_addr_bit1;
		logic burst_low_addr_bit0;
		logic [`DBSP_LANES-1:0] lane_write_n;
		logic [`DBSP_DW-1:0] data_lines;
		logic dll_disable_n;
	} dbsp_pins_s;
	// Shared data lines, driven side
	typedef struct packed {
		logic [`DBSP_DW-1:0] data_lines;
		logic data_oe;
	} dbsp_dq_s;
	typedef logic [`DBSP_AW+1:0] dbsp_addr_t;
endpackage

// [tb/dbsp_ctl_model.sv]
// Memory controller model: input clock divider, command and write data driver
module dbsp_ctl_model (
	input wire logic mclk,
	input wire logic dll_disable_n,
	input dbsp_pkg::dbsp_dq_s dq,
	output dbsp_pkg::dbsp_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ns;
	import dbsp_pkg::*;
	logic [2:0] ph = 3'h0;
	logic load_n = 1'b1;
	logic rnw = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [3:0] strb_n = 4'hF;
	logic [35:0] wdat = 36'h0;
	logic drv = 1'b0;
	logic [35:0] last = 36'h0;
	logic [35:0] rq[$];
	// K period is 8 mclk; a free-running divider keeps both pins in step
	always @(posedge mclk) begin
		ph <= ph + 3'h1;
		if (dq.data_oe || drv) last <= pins.data_lines;
		// Mid-word sampling keeps clear of the 2-3 mclk sync uncertainty
		if ((ph == 3'h2 || ph == 3'h6) && dq.data_oe === 1'b1) rq.push_back(dq.data_lines);
	end
	// Released lines show the inverse of the last value, not a steady guess
	always_comb begin
		pins.main_clk = (ph < 3'h4);
		pins.main_clk_n = (ph >= 3'h4);
		pins.out_clk = 1'b1;
		pins.out_clk_n = 1'b1;
		pins.load_n = load_n;
		pins.read_not_write = rnw;
		pins.addr_in = addr[5:2];
		pins.burst_low_addr_bit1 = addr[1];
		pins.burst_low_addr_bit0 = addr[0];
		pins.lane_write_n = strb_n;
		pins.dll_disable_n = dll_disable_n;
		pins.data_lines = dq.data_oe ? dq.data_lines : (drv ? wdat : ~last);
	end
	task automatic at_ph(input logic [2:0] p);
		do @(posedge mclk); while (ph != p);
	endtask
	// Command held over one K rise; back-to-back calls give consecutive rises
	task automatic cmd(input logic r, input logic [5:0] a);
		at_ph(3'h5);
		load_n <= 1'b0;
		rnw <= r;
		addr <= a;
		at_ph(3'h1);
		load_n <= 1'b1;
	endtask
	// Words at next K rise, K_n rise, K rise, K_n rise
	task automatic write4(input logic [5:0] a, input logic [3:0][35:0] d, input logic [3:0][3:0] s);
		cmd(1'b0, a);
		for (int i = 0; i < 4; i++) begin
			at_ph(i[0] ? 3'h1 : 3'h5);
			drv <= 1'b1;
			wdat <= d[i];
			strb_n <= s[i];
		end
		at_ph(3'h5);
		drv <= 1'b0;
		strb_n <= 4'hF;
	endtask
endmodule

// [tb/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dbsp_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic dll_disable_n = 1'b0;
	dbsp_pins_s pins;
	dbsp_dq_s dq;
	logic dll_enabled, dll_locked, busy, oe_d;
	logic [35:0] mem[64];
	int falls = 0;
	int n_errors = 0;
	int samples_checked = 0;
	dbsp_port #(.LANES(4), .DEPTH(32)) i_dbsp_port (.mclk(mclk), .rst_n(rst_n), .pins(pins),
		.dq(dq), .dll_enabled(dll_enabled), .dll_locked(dll_locked), .busy(busy));
	dbsp_ctl_model i_dbsp_ctl_model (.mclk(mclk), .dll_disable_n(dll_disable_n), .dq(dq),
		.pins(pins));
	initial forever #25 mclk = ~mclk;
	// Count drops of the drive enable, so a gap between chained bursts shows
	always @(posedge mclk) begin
		oe_d <= dq.data_oe;
		if (oe_d === 1'b1 && dq.data_oe === 1'b0) falls <= falls + 1;
	end
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_idle();
		int n;
		repeat (8) @(posedge mclk);
		for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk);
		check("busy", 36'h0, {35'h0, busy});
		if (n == 400) end_of_test();
	endtask
	// Only lanes with a low strobe take the new bits
	function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d,
		input logic [3:0] s);
		for (int l = 0; l < 4; l++) if (!s[l]) o[l*9+:9] = d[l*9+:9];
		return o;
	endfunction
	initial begin
		int n;
		int m;
		int f0;
		logic [5:0] a;
		logic [3:0][35:0] d;
		logic [3:0][3:0] s;
		logic [5:0] ra[$];
		void'($urandom(32'hE220CB76));
		for (int i = 0; i < 64; i++) mem[i] = 36'h0;
		repeat (8) @(posedge mclk);
		check("reset out", 36'h0, {dq.data_lines | 36'(dq.data_oe) | 36'(busy) | 36'(dll_locked)});
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
		check("dll off", 36'h0, {35'h0, dll_enabled});
		dll_disable_n <= 1'b1;
		repeat (8000) @(posedge mclk);
		check("early lock", 36'h0, {35'h0, dll_locked});
		for (n = 0; n < 600 && dll_locked !== 1'b1; n++) @(posedge mclk);
		check("lock", 36'h1, {35'h0, dll_locked});
		// Random bursts; first wraps from offset 2, second has every lane masked
		for (int w = 0; w < 8; w++) begin
			a = (w == 0) ? 6'h3E : 6'($urandom);
			for (int i = 0; i < 4; i++) begin
				d[i] = {4'($urandom), 32'($urandom)};
				s[i] = (w == 1) ? 4'hF : 4'($urandom);
				mem[{a[5:2], a[1:0] + 2'(i)}] = merge(mem[{a[5:2], a[1:0] + 2'(i)}], d[i], s[i]);
			end
			i_dbsp_ctl_model.write4(a, d, s);
			ra.push_back(a);
		end
		ra.push_back(6'h00);
		wait_idle();
		i_dbsp_ctl_model.rq.delete();
		f0 = falls;
		foreach (ra[k]) i_dbsp_ctl_model.cmd(1'b1, ra[k]);
		wait_idle();
		repeat (16) @(posedge mclk);
		check("word count", 36'(4 * ra.size()), 36'(i_dbsp_ctl_model.rq.size()));
		check("oe drops", 36'h1, 36'(falls - f0));
		check("oe idle", 36'h0, {35'h0, dq.data_oe});
		foreach (ra[k]) for (int i = 0; i < 4 && 4 * k + i < i_dbsp_ctl_model.rq.size(); i++)
			check("read word", mem[{ra[k][5:2], ra[k][1:0] + 2'(i)}], i_dbsp_ctl_model.rq[4 * k + i]);
		// Second chained batch in reverse order, through the read buffer of the top
		i_dbsp_ctl_model.rq.delete();
		f0 = falls;
		for (n = ra.size() - 1; n >= 0; n--) i_dbsp_ctl_model.cmd(1'b1, ra[n]);
		wait_idle();
		repeat (16) @(posedge mclk);
		check("batch count", 36'(4 * ra.size()), 36'(i_dbsp_ctl_model.rq.size()));
		m = 0;
		for (n = ra.size() - 1; n >= 0; n--) begin
			for (int i = 0; i < 4 && m < i_dbsp_ctl_model.rq.size(); i++) begin
				check("batch word", mem[{ra[n][5:2], ra[n][1:0] + 2'(i)}], i_dbsp_ctl_model.rq[m]);
				m++;
			end
		end
		check("batch drops", 36'h1, 36'(falls - f0));
		check("batch idle", 36'h0, {35'h0, dq.data_oe});
		end_of_test();
	end
endmodule
